//--- remi_consts.svh
// Offsets, field positions, reset values and timing counts for the regulator event masks.
`ifndef REMI_CONSTS_SVH
`define REMI_CONSTS_SVH
`define REMI_ADDR_CONV_MASK 8'h22
`define REMI_ADDR_LINREG_MASK 8'h23
`define REMI_BIT_R1_PG_INVALID 7
`define REMI_BIT_R1_PG_VALID 6
`define REMI_BIT_R1_CURRENT_LIMIT 4
`define REMI_BIT_R0_PG_INVALID 3
`define REMI_BIT_R0_PG_VALID 2
`define REMI_BIT_R0_CURRENT_LIMIT 0
`define REMI_WRITABLE_BITS 8'hDD
`define REMI_MASK_RESET 8'hCC
`define REMI_SYNC_STAGES 3
`endif

//--- remi_pkg.sv
// Types shared by the regulator event mask files.
package remi_pkg;
    typedef enum logic [1:0] {
        REMI_SRC_CONV0 = 2'b00,
        REMI_SRC_CONV1 = 2'b01,
        REMI_SRC_LINREG0 = 2'b10,
        REMI_SRC_LINREG1 = 2'b11
    } remi_src_e;
    typedef logic [7:0] remi_byte_t;
endpackage

//--- remi_evt_if.sv
// Interface carrying one regulator's synchronised raw status and gated events.
`timescale 1ns/10ps
interface remi_evt_if;
    logic pg_invalid;
    logic current_limit;
    logic [2:0] masks;
    logic [2:0] events;
    modport det (input pg_invalid, input current_limit, input masks, output events);
    modport ctl (output pg_invalid, output current_limit, output masks, input events);
endinterface

//--- remi_event_gate.sv
// Edge detector and mask gate for the three events of one regulator.
`timescale 1ns/10ps
module remi_event_gate
    import remi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    remi_evt_if.det evt
);
    logic pg_q_r;
    logic lim_q_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pg_q_r <= 1'b0;
            lim_q_r <= 1'b0;
        end
        else
        begin
            pg_q_r <= evt.pg_invalid;
            lim_q_r <= evt.current_limit;
        end
    end

    // Mask bit 2 is invalid, bit 1 valid, bit 0 current limit; one suppresses.
    always_comb
    begin
        evt.events[2] = evt.pg_invalid & ~pg_q_r & ~evt.masks[2];
        evt.events[1] = ~evt.pg_invalid & pg_q_r & ~evt.masks[1];
        evt.events[0] = evt.current_limit & ~lim_q_r & ~evt.masks[0];
    end
endmodule // remi_event_gate

//--- remi_masks.sv
// Regulator event mask registers with raw status passthrough and gated event pulses.
`timescale 1ns/10ps
`include "remi_consts.svh"
module remi_masks
    import remi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [3:0] pg_invalid_i,
    input wire logic [3:0] current_limit_i,
    output logic [7:0] conv_raw_status_o,
    output logic [7:0] linear_regulator_raw_status_o,
    output logic [3:0] pg_invalid_evt_o,
    output logic [3:0] pg_valid_evt_o,
    output logic [3:0] current_limit_evt_o
);
    remi_byte_t converter_event_mask_r;
    remi_byte_t linear_regulator_event_mask_r;
    remi_byte_t rdata_nxt;
    logic [`REMI_SYNC_STAGES-1:0] pg_sync_r [4];
    logic [`REMI_SYNC_STAGES-1:0] lim_sync_r [4];
    logic [3:0] pg_stable_r;
    logic [3:0] lim_stable_r;
    logic [3:0] ev_inv;
    logic [3:0] ev_val;
    logic [3:0] ev_lim;

    // Extract the three mask bits for regulator index k within a register.
    function automatic logic [2:0] remi_slice(input remi_byte_t m, input logic hi);
        if (hi)
            remi_slice = {m[`REMI_BIT_R1_PG_INVALID], m[`REMI_BIT_R1_PG_VALID],
                m[`REMI_BIT_R1_CURRENT_LIMIT]};
        else
            remi_slice = {m[`REMI_BIT_R0_PG_INVALID], m[`REMI_BIT_R0_PG_VALID],
                m[`REMI_BIT_R0_CURRENT_LIMIT]};
    endfunction

    // Reserved positions never load, so they stay at their reset zero.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            converter_event_mask_r <= `REMI_MASK_RESET;
        else if (reg_wr_i && reg_addr_i == `REMI_ADDR_CONV_MASK)
            converter_event_mask_r <= reg_wdata_i & `REMI_WRITABLE_BITS;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            linear_regulator_event_mask_r <= `REMI_MASK_RESET;
        else if (reg_wr_i && reg_addr_i == `REMI_ADDR_LINREG_MASK)
            linear_regulator_event_mask_r <= reg_wdata_i & `REMI_WRITABLE_BITS;
    end

    always_comb
    begin
        unique case (reg_addr_i)
            `REMI_ADDR_CONV_MASK: rdata_nxt = converter_event_mask_r;
            `REMI_ADDR_LINREG_MASK: rdata_nxt = linear_regulator_event_mask_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= rdata_nxt;
    end

    // Analog flags are asynchronous; a change counts once stages two and three agree.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_reg
            remi_evt_if evt ();
            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    pg_sync_r[g] <= '0;
                    lim_sync_r[g] <= '0;
                    pg_stable_r[g] <= 1'b0;
                    lim_stable_r[g] <= 1'b0;
                end
                else
                begin
                    pg_sync_r[g] <= {pg_sync_r[g][1:0], pg_invalid_i[g]};
                    lim_sync_r[g] <= {lim_sync_r[g][1:0], current_limit_i[g]};
                    if (pg_sync_r[g][1] == pg_sync_r[g][2])
                        pg_stable_r[g] <= pg_sync_r[g][2];
                    if (lim_sync_r[g][1] == lim_sync_r[g][2])
                        lim_stable_r[g] <= lim_sync_r[g][2];
                end
            end
            assign evt.pg_invalid = pg_stable_r[g];
            assign evt.current_limit = lim_stable_r[g];
            // Indices 0,1 are converters, 2,3 linear regulators.
            assign evt.masks = (g < 2) ?
                remi_slice(converter_event_mask_r, 1'(g % 2)) :
                remi_slice(linear_regulator_event_mask_r, 1'(g % 2));
            assign ev_inv[g] = evt.events[2];
            assign ev_val[g] = evt.events[1];
            assign ev_lim[g] = evt.events[0];
            remi_event_gate u_gate (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .evt(evt)
            );
        end
    endgenerate

    // Status layout mirrors the mask layout; masks never enter this path.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            conv_raw_status_o <= 8'h00;
            linear_regulator_raw_status_o <= 8'h00;
            pg_invalid_evt_o <= 4'h0;
            pg_valid_evt_o <= 4'h0;
            current_limit_evt_o <= 4'h0;
        end
        else
        begin
            conv_raw_status_o <= {1'b0, pg_stable_r[1], 1'b0, lim_stable_r[1],
                1'b0, pg_stable_r[0], 1'b0, lim_stable_r[0]};
            linear_regulator_raw_status_o <= {1'b0, pg_stable_r[3], 1'b0, lim_stable_r[3],
                1'b0, pg_stable_r[2], 1'b0, lim_stable_r[2]};
            pg_invalid_evt_o <= ev_inv;
            pg_valid_evt_o <= ev_val;
            current_limit_evt_o <= ev_lim;
        end
    end

    a_conv_valid_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        converter_event_mask_r[6] |=> !pg_valid_evt_o[1])
        else $error("conv1 valid leaked");
    a_conv0_valid_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        converter_event_mask_r[2] |=> !pg_valid_evt_o[0])
        else $error("conv0 valid leaked");
    a_conv1_lim_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        converter_event_mask_r[4] |=> !current_limit_evt_o[1])
        else $error("conv1 lim leaked");
    a_conv0_lim_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        converter_event_mask_r[0] |=> !current_limit_evt_o[0])
        else $error("conv0 lim leaked");
    a_conv1_inv_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        converter_event_mask_r[7] |=> !pg_invalid_evt_o[1])
        else $error("conv1 inv leaked");
    a_conv0_inv_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        converter_event_mask_r[3] |=> !pg_invalid_evt_o[0])
        else $error("conv0 inv leaked");
    a_lin1_inv_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        linear_regulator_event_mask_r[7] |=> !pg_invalid_evt_o[3])
        else $error("lin1 inv leaked");
    a_lin1_val_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        linear_regulator_event_mask_r[6] |=> !pg_valid_evt_o[3])
        else $error("lin1 val leaked");
    a_lin0_inv_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        linear_regulator_event_mask_r[3] |=> !pg_invalid_evt_o[2])
        else $error("lin0 inv leaked");
    a_lin0_val_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        linear_regulator_event_mask_r[2] |=> !pg_valid_evt_o[2])
        else $error("lin0 val leaked");
    a_lin_lim_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        linear_regulator_event_mask_r[4] |=> !current_limit_evt_o[3])
        else $error("lin1 lim leaked");
    a_lin0_lim_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        linear_regulator_event_mask_r[0] |=> !current_limit_evt_o[2])
        else $error("lin0 lim leaked");
    a_conv_inv_event: assert property (@(posedge clk_i) disable iff (rst_i)
        pg_invalid_evt_o[0] |-> $past(pg_stable_r[0]) && !$past(pg_stable_r[0], 2))
        else $error("conv0 invalid event without rise");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ((converter_event_mask_r | linear_regulator_event_mask_r) & 8'h22) == 8'h00)
        else $error("reserved bit set");
    a_raw_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        linear_regulator_raw_status_o[6] == $past(pg_stable_r[3]))
        else $error("raw lost");
    a_conv_mask_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> converter_event_mask_r == `REMI_MASK_RESET)
        else $error("conv mask not at default after reset");
    a_lin_mask_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> linear_regulator_event_mask_r == `REMI_MASK_RESET)
        else $error("linear mask not at default after reset");

    // Both raw bytes side by side, so one loop can index every regulator's bits.
    logic [15:0] raw_both;
    assign raw_both = {linear_regulator_raw_status_o, conv_raw_status_o};

    // Every pulse must trace back to a real edge of the settled level; raw status
    // tracks that level one cycle later with no mask in its path.
    for (genvar k = 0; k < 4; k++)
    begin : g_chk
        a_inv_after_rise: assert property (@(posedge clk_i) disable iff (rst_i)
            pg_invalid_evt_o[k] |-> $past(pg_stable_r[k]) && !$past(pg_stable_r[k], 2))
            else $error("invalid event without rise");
        a_val_after_fall: assert property (@(posedge clk_i) disable iff (rst_i)
            pg_valid_evt_o[k] |-> !$past(pg_stable_r[k]) && $past(pg_stable_r[k], 2))
            else $error("valid event without fall");
        a_lim_after_rise: assert property (@(posedge clk_i) disable iff (rst_i)
            current_limit_evt_o[k] |-> $past(lim_stable_r[k]) && !$past(lim_stable_r[k], 2))
            else $error("limit event without rise");
        a_raw_pg_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
            raw_both[4 * k + 2] == $past(pg_stable_r[k]))
            else $error("raw power-good lost");
        a_raw_lim_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
            raw_both[4 * k] == $past(lim_stable_r[k]))
            else $error("raw current limit lost");
    end
endmodule // remi_masks

//--- remi_host_model.sv
// Host processor model that writes and reads the mask registers.
`timescale 1ns/10ps
module remi_host_model
(
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    initial
    begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Write data is inverted once the strobe drops, so a stale value is never read as fresh.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule // remi_host_model

//--- regulator_event_interrupt_masks_tb.sv
// Testbench for the regulator event masks: register access, event gating and raw status.
`timescale 1ns/10ps
module regulator_event_interrupt_masks_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic clr = 1'b0;
    logic reg_wr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_raw, lin_raw, rd_v;
    logic [3:0] pg_inv = 4'h0, cur_lim = 4'h0, evt_inv, evt_val, evt_lim;
    logic [11:0] seen;
    int err_total = 0;
    int n_compared = 0;
    always #12.5 clk_i = ~clk_i;
    remi_masks u_remi_masks (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .pg_invalid_i(pg_inv), .current_limit_i(cur_lim), .conv_raw_status_o(conv_raw),
        .linear_regulator_raw_status_o(lin_raw), .pg_invalid_evt_o(evt_inv),
        .pg_valid_evt_o(evt_val), .current_limit_evt_o(evt_lim));
    remi_host_model u_remi_host_model (.clk_i(clk_i), .addr_o(reg_addr), .wr_o(reg_wr),
        .wdata_o(reg_wdata), .rdata_i(reg_rdata));
    // Pulses last one cycle, so they are collected here and judged once the path settles.
    always @(posedge clk_i)
    begin
        if (clr)
            seen <= 12'h000;
        else
            seen <= seen | {evt_inv, evt_val, evt_lim};
    end
    function automatic logic [7:0] raw(input logic [1:0] p, input logic [1:0] c);
        return {1'b0, p[1], 1'b0, c[1], 1'b0, p[0], 1'b0, c[0]};
    endfunction
    task automatic report_and_stop();
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp12(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: events got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        u_remi_host_model.wr(a, d);
        u_remi_host_model.rd(a, rd_v);
        cmp8(rd_v, exp);
    endtask
    // Drives new levels, then judges collected pulses {invalid, valid, limit} and raw status.
    task automatic ev(input logic [3:0] p, input logic [3:0] c, input logic [11:0] exp);
        @(negedge clk_i);
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        pg_inv = p;
        cur_lim = c;
        repeat (10) @(negedge clk_i);
        cmp12(seen, exp);
        cmp8(conv_raw, raw(p[1:0], c[1:0]));
        cmp8(lin_raw, raw(p[3:2], c[3:2]));
    endtask
    task automatic t_reset();
        u_remi_host_model.rd(8'h22, rd_v);
        cmp8(rd_v, 8'hCC);
        u_remi_host_model.rd(8'h23, rd_v);
        cmp8(rd_v, 8'hCC);
        u_remi_host_model.rd(8'h24, rd_v);
        cmp8(rd_v, 8'h00);
    endtask
    task automatic t_gating();
        ev(4'hF, 4'hF, 12'h00F);
        ev(4'h0, 4'h0, 12'h000);
        wr_rd(8'h22, 8'h00, 8'h00);
        wr_rd(8'h23, 8'hFF, 8'hDD);
        ev(4'hF, 4'hF, 12'h303);
        ev(4'h0, 4'h0, 12'h030);
        wr_rd(8'h22, 8'hFF, 8'hDD);
        wr_rd(8'h23, 8'h00, 8'h00);
        wr_rd(8'h24, 8'h00, 8'h00);
        u_remi_host_model.rd(8'h22, rd_v);
        cmp8(rd_v, 8'hDD);
        ev(4'hF, 4'hF, 12'hC0C);
        ev(4'h0, 4'h0, 12'h0C0);
    endtask
    // A reset in mid-run must bring both masks back to their defaults.
    task automatic t_mid_reset();
        @(negedge clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
    endtask
    initial
    begin
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_gating();
        t_mid_reset();
        report_and_stop();
    end
    // The sequence needs some 110 cycles; the 2000-cycle limit means a hang.
    initial
    begin
        #(25 * 2000);
        err_total++;
        report_and_stop();
    end
endmodule // regulator_event_interrupt_masks_tb
